// file: hdl/thermal_alarm_pkg.sv
// Constants, types and state records shared by the thermal alarm and address match block
// Summary of operation
// RULE_01: Comparator mode: alarm on above trip setpoint
// RULE_02: Comparator mode: alarm clears only below hysteresis
// RULE_03: Interrupt mode: trip sets alarm, register read clears
// RULE_04: Interrupt mode: then below-hysteresis alarms, read clears
// RULE_05: Interrupt mode: entering shutdown forces alarm inactive
// RULE_06: Polarity bit sets alarm active level
// RULE_07: Polarity defaults to active low after reset
// RULE_08: Alarm pin only pulls low or releases
// RULE_09: Address byte upper nibble must be fixed prefix
// RULE_10: Low three address bits match select pins
// RULE_11: Master drives clock; device only receives it
// RULE_12: Data line bidirectional: receive, acknowledge, read data
// RULE_13: Last address bit selects read or write
// RULE_14: Comparator mode holds alarm during shutdown
// RULE_15: Alarm changes after programmed consecutive results, max six
// RULE_16: Compare once per conversion; equality never crosses
// RULE_17: Latch address select pins at start condition
package thermal_alarm_pkg;

  localparam int TEMP_W = 9;
  localparam int ADDR_SEL_W = 3;
  localparam int FQ_W = 3;

  localparam logic [3:0] FIXED_ADDRESS_PREFIX = 4'h9;
  localparam logic [FQ_W-1:0] FAULT_QUEUE_MIN = 3'h1;
  localparam logic [FQ_W-1:0] FAULT_QUEUE_MAX = 3'h6;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ADDR  = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ  = 2'b11
  } link_phase_t;

  typedef enum logic {
    WATCH_TRIP = 1'b0,
    WATCH_LOW  = 1'b1
  } int_watch_t;

  typedef struct packed {
    logic shutdown;
    logic int_mode;
    logic alarm_polarity_bit;
    logic [FQ_W-1:0] fault_queue;
  } alarm_cfg_t;

  localparam alarm_cfg_t CFG_RESET = '{
    shutdown: 1'b0,
    int_mode: 1'b0,
    alarm_polarity_bit: 1'b0,
    fault_queue: 3'h1
  };

  typedef struct packed {
    alarm_cfg_t cfg;
    logic shutdown_d;
    logic [FQ_W-1:0] hot_cnt;
    logic [FQ_W-1:0] cold_cnt;
    logic alarm_active;
    int_watch_t watch;
    logic [2:0] rd_sync;
    logic alarm_oe;
    logic alarm_out;
  } sys_state_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [ADDR_SEL_W-1:0] pin_s1;
    logic [ADDR_SEL_W-1:0] pin_s2;
    logic [ADDR_SEL_W-1:0] addr_sel;
    logic frame_tgl;
    logic sda_oe;
    logic sda_out;
  } link_fall_t;

  typedef struct packed {
    logic sda_hi;
    logic frame_seen;
    link_phase_t phase;
    logic [3:0] bit_idx;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic ack_pend;
    logic read_tgl;
    logic [7:0] wr_byte;
    logic wr_valid;
  } link_rise_t;

endpackage

// file: hdl/thermal_alarm_and_address_match.sv
// Thermal alarm output logic and two-wire slave address match
module thermal_alarm_and_address_match
  import thermal_alarm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_done,
  input wire logic signed [TEMP_W-1:0] temp_result,
  input wire logic signed [TEMP_W-1:0] trip_setpoint,
  input wire logic signed [TEMP_W-1:0] hysteresis_limit,
  input wire alarm_cfg_t cfg_in,
  input wire logic cfg_wr,
  output alarm_cfg_t alarm_cfg,
  output logic alarm_active,
  output logic thermal_alarm_out,
  output logic thermal_alarm_oe,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit2,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit0,
  input wire logic [7:0] rd_byte,
  output logic [7:0] wr_byte,
  output logic wr_valid
);

  localparam sys_state_t SYS_RESET = '{
    cfg: CFG_RESET,
    shutdown_d: 1'b0,
    hot_cnt: 3'h0,
    cold_cnt: 3'h0,
    alarm_active: 1'b0,
    watch: WATCH_TRIP,
    rd_sync: 3'h0,
    alarm_oe: 1'b0,
    alarm_out: 1'b0
  };

  localparam link_rise_t RISE_RESET = '{
    sda_hi: 1'b1,
    frame_seen: 1'b0,
    phase: PH_IDLE,
    bit_idx: 4'h0,
    shreg: 8'h00,
    tx: 8'h00,
    ack_pend: 1'b0,
    read_tgl: 1'b0,
    wr_byte: 8'h00,
    wr_valid: 1'b0
  };

  sys_state_t sys_reg;
  sys_state_t sys_next;
  link_fall_t fall_reg;
  link_fall_t fall_next;
  link_rise_t rise_reg;
  link_rise_t rise_next;

  logic link_rst;
  assign link_rst = fall_reg.rst_sync[1];

  // ---------------------------------------------------------------------------
  // Link side, SCL falling edge: reset sync, start detect, pin latch, SDA drive.
  // SCL comes only from the master; nothing here drives it.
  // ---------------------------------------------------------------------------
  always_comb begin : fall_logic
    logic start;
    logic ack_drive;
    logic read_drive;
    start = 1'b0;
    ack_drive = 1'b0;
    read_drive = 1'b0;
    fall_next = fall_reg;
    fall_next.rst_sync = {fall_reg.rst_sync[0], rst};
    fall_next.pin_s1 = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    fall_next.pin_s2 = fall_reg.pin_s1;
    fall_next.sda_out = 1'b0;
    if (link_rst) begin
      fall_next.addr_sel = '0;
      fall_next.frame_tgl = 1'b0;
      fall_next.sda_oe = 1'b0;
    end else begin
      // SDA high at the last rise and low now: it fell while SCL was high
      start = rise_reg.sda_hi & ~sda_in;
      ack_drive = (rise_reg.bit_idx == ACK_SLOT) && rise_reg.ack_pend;
      read_drive = (rise_reg.phase == PH_READ) && (rise_reg.bit_idx != ACK_SLOT)
                   && !rise_reg.tx[7];
      if (start) begin
        fall_next.frame_tgl = ~fall_reg.frame_tgl;
        fall_next.addr_sel = fall_reg.pin_s2; // RULE_17
        fall_next.sda_oe = 1'b0;
      end else begin
        // Changes only while SCL is low, so the master never sees a false start
        fall_next.sda_oe = ack_drive | read_drive; // RULE_12
      end
    end
  end

  always_ff @(negedge scl) begin
    fall_reg <= fall_next;
  end

  // ---------------------------------------------------------------------------
  // Link side, SCL rising edge: bit sampling, address compare, byte framing.
  // ---------------------------------------------------------------------------
  always_comb begin : rise_logic
    logic [7:0] full_byte;
    logic addr_match;
    full_byte = {rise_reg.shreg[6:0], sda_in};
    addr_match = (full_byte[7:4] == FIXED_ADDRESS_PREFIX) // RULE_09
                 && (full_byte[3:1] == fall_reg.addr_sel); // RULE_10
    rise_next = rise_reg;
    rise_next.sda_hi = sda_in;
    rise_next.wr_valid = 1'b0;
    if (link_rst) begin
      rise_next = RISE_RESET;
    end else if (rise_reg.frame_seen != fall_reg.frame_tgl) begin
      // First rise after a start carries the address MSB
      rise_next.frame_seen = fall_reg.frame_tgl;
      rise_next.phase = PH_ADDR;
      rise_next.shreg = {7'h00, sda_in};
      rise_next.bit_idx = 4'h1;
      rise_next.ack_pend = 1'b0;
    end else if (rise_reg.phase != PH_IDLE) begin
      if (rise_reg.bit_idx == ACK_SLOT) begin
        rise_next.bit_idx = 4'h0;
        rise_next.ack_pend = 1'b0;
        unique case (rise_reg.phase)
          PH_ADDR: begin
            if (!rise_reg.ack_pend) begin
              rise_next.phase = PH_IDLE;
            end else if (rise_reg.shreg[0]) begin // RULE_13
              rise_next.phase = PH_READ;
              rise_next.tx = rd_byte;
            end else begin
              rise_next.phase = PH_WRITE;
            end
          end
          PH_WRITE: begin
            rise_next.phase = PH_WRITE;
          end
          PH_READ: begin
            // Every finished read byte counts as a register read
            rise_next.read_tgl = ~rise_reg.read_tgl; // RULE_03
            if (sda_in) begin
              rise_next.phase = PH_IDLE;
            end else begin
              rise_next.tx = rd_byte;
            end
          end
          PH_IDLE: begin
            rise_next.phase = PH_IDLE;
          end
        endcase
      end else begin
        rise_next.shreg = full_byte; // RULE_11
        rise_next.bit_idx = rise_reg.bit_idx + 4'h1;
        if (rise_reg.phase == PH_READ) begin
          rise_next.tx = {rise_reg.tx[6:0], 1'b0};
        end
        if (rise_reg.bit_idx == LAST_DATA_BIT) begin
          if (rise_reg.phase == PH_ADDR) begin
            rise_next.ack_pend = addr_match; // RULE_10
          end else if (rise_reg.phase == PH_WRITE) begin
            rise_next.ack_pend = 1'b1;
            rise_next.wr_byte = full_byte;
            rise_next.wr_valid = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge scl) begin
    rise_reg <= rise_next;
  end

  // ---------------------------------------------------------------------------
  // System side: threshold filter, alarm state, open-collector pin.
  // ---------------------------------------------------------------------------
  always_comb begin : sys_logic
    logic read_evt;
    logic hot;
    logic cold;
    logic hot_q;
    logic cold_q;
    logic set_evt;
    logic [FQ_W-1:0] fq;
    read_evt = 1'b0;
    hot = 1'b0;
    cold = 1'b0;
    hot_q = 1'b0;
    cold_q = 1'b0;
    set_evt = 1'b0;
    fq = sys_reg.cfg.fault_queue;
    if (fq < FAULT_QUEUE_MIN) begin
      fq = FAULT_QUEUE_MIN;
    end else if (fq > FAULT_QUEUE_MAX) begin
      fq = FAULT_QUEUE_MAX;
    end
    sys_next = sys_reg;
    sys_next.rd_sync = {sys_reg.rd_sync[1:0], rise_reg.read_tgl};
    read_evt = sys_reg.rd_sync[2] ^ sys_reg.rd_sync[1];
    if (rst) begin
      sys_next = SYS_RESET; // RULE_07
    end else begin
      if (cfg_wr) begin
        sys_next.cfg = cfg_in; // RULE_06
      end
      sys_next.shutdown_d = sys_reg.cfg.shutdown;
      // Conversions are halted in shutdown, so nothing is evaluated there
      if (conv_done && !sys_reg.cfg.shutdown) begin
        hot = temp_result > trip_setpoint; // RULE_16
        cold = temp_result < hysteresis_limit; // RULE_16
        sys_next.hot_cnt = !hot ? 3'h0 :
                           (sys_reg.hot_cnt < FAULT_QUEUE_MAX) ? sys_reg.hot_cnt + 3'h1 :
                           sys_reg.hot_cnt;
        sys_next.cold_cnt = !cold ? 3'h0 :
                            (sys_reg.cold_cnt < FAULT_QUEUE_MAX) ? sys_reg.cold_cnt + 3'h1 :
                            sys_reg.cold_cnt;
        hot_q = hot && (sys_next.hot_cnt >= fq); // RULE_15
        cold_q = cold && (sys_next.cold_cnt >= fq); // RULE_15
      end
      if (!sys_reg.cfg.int_mode) begin
        // Holding when no result is qualified also keeps state over shutdown
        if (hot_q) begin
          sys_next.alarm_active = 1'b1; // RULE_01
        end else if (cold_q) begin
          sys_next.alarm_active = 1'b0; // RULE_02 RULE_14
        end
      end else begin
        set_evt = (sys_reg.watch == WATCH_TRIP) ? hot_q : cold_q; // RULE_04
        if (set_evt) begin
          // A new event in the same cycle as a read wins over the clear
          sys_next.alarm_active = 1'b1; // RULE_03
        end else if (read_evt && sys_reg.alarm_active) begin
          sys_next.alarm_active = 1'b0; // RULE_03
          sys_next.watch = (sys_reg.watch == WATCH_TRIP) ? WATCH_LOW : WATCH_TRIP; // RULE_04
        end
        if (sys_reg.cfg.shutdown && !sys_reg.shutdown_d) begin
          sys_next.alarm_active = 1'b0; // RULE_05
        end
      end
    end
    // Pull low when the pin must read low; never drive high
    sys_next.alarm_out = 1'b0; // RULE_08
    sys_next.alarm_oe = sys_next.cfg.alarm_polarity_bit ? ~sys_next.alarm_active :
                        sys_next.alarm_active; // RULE_06 RULE_08
  end

  always_ff @(posedge sys_clk) begin
    sys_reg <= sys_next;
  end

  assign alarm_cfg = sys_reg.cfg;
  assign alarm_active = sys_reg.alarm_active;
  assign thermal_alarm_out = sys_reg.alarm_out;
  assign thermal_alarm_oe = sys_reg.alarm_oe;
  assign sda_out = fall_reg.sda_out;
  assign sda_oe = fall_reg.sda_oe;
  assign wr_byte = rise_reg.wr_byte;
  assign wr_valid = rise_reg.wr_valid;

endmodule // thermal_alarm_and_address_match

// file: tb/alarm_checker.sv
// Port-level assertions for the thermal alarm and address match block
module alarm_checker
  import thermal_alarm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_done,
  input wire logic signed [TEMP_W-1:0] temp_result,
  input wire logic signed [TEMP_W-1:0] trip_setpoint,
  input wire logic signed [TEMP_W-1:0] hysteresis_limit,
  input wire alarm_cfg_t cfg_in,
  input wire logic cfg_wr,
  input wire alarm_cfg_t alarm_cfg,
  input wire logic alarm_active,
  input wire logic thermal_alarm_out,
  input wire logic thermal_alarm_oe,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wr_valid
);
  logic run, hot, cold, fq1;
  assign run = conv_done && !alarm_cfg.shutdown;
  assign hot = temp_result > trip_setpoint;
  assign cold = temp_result < hysteresis_limit;
  assign fq1 = !alarm_cfg.int_mode && alarm_cfg.fault_queue <= 3'h1;
  property p_pol;
    @(posedge sys_clk) disable iff (rst)
      thermal_alarm_oe == (alarm_cfg.alarm_polarity_bit ^ alarm_active);
  endproperty
  a_pol: assert property (p_pol) else $error("alarm enable wrong");
  property p_cfg;
    @(posedge sys_clk) disable iff (rst) cfg_wr |=> alarm_cfg == $past(cfg_in);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not loaded");
  property p_rst;
    @(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> alarm_cfg == CFG_RESET && !thermal_alarm_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_set;
    @(posedge sys_clk) disable iff (rst) run && fq1 && hot |=> alarm_active;
  endproperty
  a_set: assert property (p_set) else $error("alarm not set");
  property p_clr;
    @(posedge sys_clk) disable iff (rst) run && fq1 && cold |=> !alarm_active;
  endproperty
  a_clr: assert property (p_clr) else $error("alarm not cleared");
  // Comparator state may only move right after a crossing conversion
  property p_steady;
    @(posedge sys_clk) disable iff (rst)
      !alarm_cfg.int_mode && !cfg_wr && !(run && (hot || cold)) |=> $stable(alarm_active);
  endproperty
  a_steady: assert property (p_steady) else $error("alarm moved");
  property p_shut;
    @(posedge sys_clk) disable iff (rst)
      alarm_cfg.int_mode && $rose(alarm_cfg.shutdown) |=> !alarm_active;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown kept alarm");
  property p_od;
    @(posedge sys_clk) disable iff (rst) !thermal_alarm_out && !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_wr_ack;
    @(posedge scl) disable iff (rst) wr_valid |-> sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  c_set: cover property (@(posedge sys_clk) $rose(alarm_active));
  c_shut: cover property (@(posedge sys_clk) $rose(alarm_cfg.shutdown));
  c_wr: cover property (@(posedge scl) wr_valid);
endmodule // alarm_checker

// file: tb/link_master.sv
// Two-wire bus master model: idle clock pulses ahead of each start, data released high
module link_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic pulse();
    scl = 1'b0;
    #8 scl = 1'b1;
    #8 seen = sda_w;
    #8 scl = 1'b0;
    #8;
  endtask
  // Low pulses first: the device misses a start straight after a stop
  task automatic start();
    sda_drv = 1'b1;
    repeat (3) pulse();
    #8 scl = 1'b1;
    #8 sda_drv = 1'b0;
    #8 scl = 1'b0;
    #8;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      pulse();
    end
    sda_drv = 1'b1;
    pulse();
    ack = !seen;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] b);
    sda_drv = 1'b1;
    repeat (8) begin
      pulse();
      b = {b[6:0], seen};
    end
    sda_drv = nack;
    pulse();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #8 scl = 1'b1;
    #8 sda_drv = 1'b1;
    #16;
  endtask
endmodule // link_master

// file: tb/testbench.sv
// Self-checking bench for the thermal alarm and address match block
module testbench
  import thermal_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, conv_done = 1'b0, cfg_wr = 1'b0, pol = 1'b0;
  logic signed [TEMP_W-1:0] temp_result = '0, trip_setpoint = 9'h050;
  logic signed [TEMP_W-1:0] hysteresis_limit = 9'h04B;
  alarm_cfg_t cfg_in = CFG_RESET, alarm_cfg;
  logic alarm_active, thermal_alarm_out, thermal_alarm_oe, scl, sda_in, sda_out, sda_oe;
  logic addr_select_bit2 = 1'b1, addr_select_bit1 = 1'b0, addr_select_bit0 = 1'b1;
  logic [7:0] rd_byte = 8'hA5, wr_byte, got;
  logic wr_valid, sda_drv, alarm_w, ack;
  int err_total = 0, samples_checked = 0, n;
  // Both open-drain wires have pull-ups
  assign sda_in = sda_drv & ~sda_oe;
  assign alarm_w = ~thermal_alarm_oe;
  always #20 sys_clk = ~sys_clk;
  thermal_alarm_and_address_match DUT (.*);
  link_master mst (.scl(scl), .sda_drv(sda_drv), .sda_w(sda_in));
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_alarm(logic a);
    // Reduce to one bit first so the inversion is not widened to the byte argument
    logic exp_w;
    exp_w = pol ^ ~a;
    check(alarm_active, a);
    check(alarm_w, exp_w);
  endtask
  task automatic conv(logic signed [TEMP_W-1:0] t);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    temp_result <= t;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic set_cfg(logic sd, logic im, logic p, logic [2:0] fq);
    @(posedge sys_clk);
    cfg_in <= '{sd, im, p, fq};
    cfg_wr <= 1'b1;
    pol = p;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic frame(logic [7:0] adr, logic exp_ack);
    mst.start();
    mst.put_byte(adr, ack);
    check(ack, exp_ack);
    if (ack && !adr[0]) begin
      mst.put_byte(8'h3C, ack);
      check(ack, 1'b1);
      check(wr_byte, 8'h3C);
    end else if (ack) begin
      mst.get_byte(1'b1, got);
      check(got, rd_byte);
    end
    mst.stop();
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    fork
      repeat (6) mst.pulse();
      repeat (5) @(posedge sys_clk);
    join
    @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check(alarm_cfg, CFG_RESET);
    chk_alarm(1'b0);
    $display("reset test done");
    conv(9'h051);
    chk_alarm(1'b1);
    conv(9'h050);
    chk_alarm(1'b1);
    conv(9'h04B);
    chk_alarm(1'b1);
    conv(9'h04A);
    chk_alarm(1'b0);
    conv(9'h050);
    chk_alarm(1'b0);
    for (int q = 2; q <= 7; q++) begin
      n = (q > 6) ? 6 : q;
      set_cfg(1'b0, 1'b0, 1'b1, q[2:0]);
      repeat (n - 1) conv(9'h060);
      conv(9'h050);
      repeat (n - 1) conv(9'h060);
      chk_alarm(1'b0);
      conv(9'h060);
      chk_alarm(1'b1);
      repeat (n - 1) conv(9'h1F0);
      chk_alarm(1'b1);
      conv(9'h1F0);
      chk_alarm(1'b0);
    end
    set_cfg(1'b0, 1'b0, 1'b1, 3'h1);
    conv(9'h060);
    set_cfg(1'b1, 1'b0, 1'b1, 3'h1);
    conv(9'h1F0);
    chk_alarm(1'b1);
    set_cfg(1'b0, 1'b0, 1'b0, 3'h1);
    conv(9'h1F0);
    $display("comparator test done");
    set_cfg(1'b0, 1'b1, 1'b0, 3'h1);
    conv(9'h060);
    conv(9'h1F0);
    chk_alarm(1'b1);
    frame(8'h9B, 1'b1);
    chk_alarm(1'b0);
    conv(9'h060);
    chk_alarm(1'b0);
    conv(9'h1F0);
    chk_alarm(1'b1);
    frame(8'h9B, 1'b1);
    chk_alarm(1'b0);
    conv(9'h060);
    set_cfg(1'b1, 1'b1, 1'b0, 3'h1);
    chk_alarm(1'b0);
    $display("interrupt test done");
    // Prefix and pin mismatches, every bit but the direction bit
    for (int b = 1; b < 8; b++) frame(8'h9A ^ (8'h01 << b), 1'b0);
    fork
      frame({FIXED_ADDRESS_PREFIX, 3'b101, 1'b0}, 1'b1);
      begin
        #200;
        @(posedge sys_clk);
        addr_select_bit1 <= 1'b1;
      end
    join
    frame({FIXED_ADDRESS_PREFIX, 3'b111, 1'b1}, 1'b1);
    $display("address test done");
    give_verdict();
  end
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule // testbench
bind thermal_alarm_and_address_match alarm_checker chk (.*);
